// file: zone_decoder_pkg.sv
// constants for the processor address zone decoder
package zone_decoder_pkg;
    // address widths
    localparam int ADDR_W = 34;
    localparam int IO_ADDR_W = 32;
    // zone codes on address bits 33:30
    localparam logic [3:0] ZONE_CACHED = 4'h0;
    localparam logic [3:0] ZONE_NOBCACHE = 4'h4;
    localparam logic [3:0] ZONE_NODCACHE = 4'h6;
    localparam logic [3:0] ZONE_ROM = 4'h8;
    localparam logic [3:0] ZONE_INTACK = 4'h9;
    localparam logic [3:0] ZONE_PMEM = 4'ha;
    localparam logic [3:0] ZONE_PIO = 4'hb;
    // transfer sizes on address bits 6:5
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_TRI = 2'h2;
    localparam logic [1:0] SIZE_LONG = 2'h3;
    // byte lanes, active low, none asserted
    localparam logic [3:0] LANES_OFF = 4'hf;
    // read acknowledge codes toward the processor
    localparam logic [2:0] ACK_NONE = 3'h0;
    localparam logic [2:0] ACK_FILL = 3'h1;
    localparam logic [2:0] ACK_NODCACHE = 3'h2;
    // cycle acknowledge code for locally ended barrier commands
    localparam logic [2:0] CACK_OK = 3'h1;
    // system register layout
    localparam int SYSREG_LO = 8;
    localparam int SYSREG_HI = 31;
    localparam int IOUPPER_LO = 26;
    localparam logic [23:0] SYSREG_RST = 24'h000000;
    // command codes from the processor
    localparam logic [2:0] CMD_READ = 3'h1;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] CMD_BARRIER = 3'h3;
    // count at which each memory phase ends; a phase takes 5 cycles
    localparam logic [3:0] MEM_PHASE_CYC = 4'h4;
endpackage

// file: cpu_address_zone_decoder.sv
// address zone decoder and bridge between processor, memory and io bus
//
// Behaviour
// - address is 34 bits; top bit zero means memory, one means io
// - zones 0000 cached, 0100 bypass backup cache, 0110 also no dcache
// - io zones: 1000 rom, 1001 intack, 1010 pmem, 1011 pio, 11xx expansion
// - cached read miss: fill backup cache, then acknowledge
// - dirty valid fill block is written to dram before read data return
// - dirty write: write back, read background, merge, mark valid dirty
// - uncached zones: no victim, backup cache untouched, writes to dram
// - no-dcache zone acknowledge forbids data cache load; single fill
// - cpu master: io address 31:23 from register, 22:2 from cpu 29:9
// - dma master: io address 25:5 passes unshifted to cpu address 25:5
// - octaword selects act as address bit 4 during dma
// - expansion lanes from address 8:7, transfer size from address 6:5
// - io transfer length from bits 6:5; lanes chosen by bits 8:7
// - io byte enables active low per lane and length table
// - rom read: rom byte on 7:0, system register on upper bits
// - rom zone write loads system register, bits 31:8 same place
// - host zones start with address strobe, end on peripheral ready
// - host cycle type bits encoded per zone and direction
// - expansion zone ignored, barriers there acknowledged locally
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module cpu_address_zone_decoder #(
    parameter int ROM_AW = 20
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // processor request
    input  wire logic          cmdValid,
    input  wire logic [2:0]    cmdCode,
    input  wire logic [33:0]   cpuAddr,
    input  wire logic [31:0]   cpuWrData,
    input  wire logic          blockValid,
    input  wire logic          blockDirty,
    // processor answers
    output logic      [2:0]    readAck,
    output logic      [2:0]    cycleAck,
    output logic      [31:0]   cpuRdData,
    output logic               cmdBusy,
    // memory and backup cache control
    output logic               dramVictimWr,
    output logic               dramRead,
    output logic               dramWrite,
    output logic               bcacheFill,
    output logic               bcacheMerge,
    output logic               bcacheMarkDirty,
    // io address bus and byte lanes
    output logic      [31:2]   ioAddr,
    output logic      [3:0]    peripheral_byte_lanes,
    output logic      [1:0]    expansion_byte_lanes,
    output logic      [1:0]    expansion_transfer_size,
    output logic               expansionSelect,
    // dma path
    input  wire logic          dmaActive,
    input  wire logic [25:5]   dmaIoAddr,
    input  wire logic          octaword_select_upper,
    input  wire logic          octaword_select_lower,
    output logic      [25:4]   dmaCpuAddr,
    // debug rom
    output logic      [ROM_AW-1:0] romAddr,
    input  wire logic [7:0]    romData,
    output logic      [23:0]   sysReg,
    // peripheral host bus
    output logic               hostAddrStrobe_n,
    output logic               hostMemIo,
    output logic               hostDataCtl,
    output logic               hostWriteRead,
    input  wire logic          hostReady_n,
    input  wire logic [31:0]   hostRdData
);
    // ****************************************
    // decode helpers
    // ****************************************
    // byte enables from lane and size codes
    function automatic logic [3:0] laneDecode(input logic [3:0] a);
        logic [3:0] r;
        r = zone_decoder_pkg::LANES_OFF;
        unique case (a[1:0])
            // lengths from 6:5 with lanes 8:7
            zone_decoder_pkg::SIZE_BYTE: r = ~(4'h1 << a[3:2]);
            zone_decoder_pkg::SIZE_WORD: begin
                // word at lane 11 is reserved
                if (a[3:2] != 2'h3) r = ~(4'h3 << a[3:2]);
            end
            zone_decoder_pkg::SIZE_TRI: begin
                if (a[3:2] == 2'h0) r = 4'h8;
                else if (a[3:2] == 2'h1) r = 4'h1;
            end
            zone_decoder_pkg::SIZE_LONG: begin
                if (a[3:2] == 2'h2) r = 4'h0;
            end
        endcase
        return r;
    endfunction

    // zones that run a host bus cycle
    function automatic logic isHostZone(input logic [3:0] z);
        return z == zone_decoder_pkg::ZONE_INTACK
            || z == zone_decoder_pkg::ZONE_PMEM
            || z == zone_decoder_pkg::ZONE_PIO;
    endfunction

    function automatic logic isLocalZone(input logic [3:0] z);
        return !z[3] || z == zone_decoder_pkg::ZONE_ROM || isHostZone(z);
    endfunction

    // only the cached zone uses the backup cache
    function automatic logic isCachedZone(input logic [3:0] z);
        return z == zone_decoder_pkg::ZONE_CACHED;
    endfunction

    // write commands carry data
    function automatic logic isWriteCmd(input logic [2:0] c);
        return c == zone_decoder_pkg::CMD_WRITE;
    endfunction

    // ****************************************
    // request sequencer
    // ****************************************
    typedef enum logic [2:0] {
        IDLE    = 3'h0,
        VICTIM  = 3'h1,
        FETCH   = 3'h3,
        FILL    = 3'h2,
        ANSWER  = 3'h6,
        HOST    = 3'h7,
        STORE   = 3'h5
    } seq_e;

    seq_e       state_q;
    logic [3:0] cnt_q;
    logic [3:0] zone_q;
    logic       isWrite_q;
    logic [33:0] addr_q;
    logic [31:0] wdata_q;

    logic [3:0] zoneIn;
    logic       cntDone;
    assign zoneIn  = cpuAddr[33:30];
    assign cntDone = (cnt_q == zone_decoder_pkg::MEM_PHASE_CYC);
    logic       cmdTake;
    logic       busyNext;
    logic       hostStart;
    logic [31:0] hostData_q;
    // request leaves idle on this edge
    assign cmdTake = state_q == IDLE && cmdValid
        && cmdCode != zone_decoder_pkg::CMD_BARRIER && isLocalZone(zoneIn);
    // busy matches the state after this edge
    assign busyNext = cmdTake || (state_q != IDLE && state_q != ANSWER);
    // host cycle begins on this edge
    assign hostStart = cmdTake && isHostZone(zoneIn);

    // request capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zone_q    <= 4'h0;
            isWrite_q <= 1'b0;
            addr_q    <= 34'h000000000;
            wdata_q   <= 32'h00000000;
        end else if (state_q == IDLE && cmdValid) begin
            zone_q    <= zoneIn;
            isWrite_q <= isWriteCmd(cmdCode);
            addr_q    <= cpuAddr;
            wdata_q   <= cpuWrData;
        end
    end

    // phase counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_q == IDLE || cntDone)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_q + 4'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= IDLE;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (cmdTake) begin
                        if (!cpuAddr[33]) begin
                            if (isCachedZone(zoneIn)
                                && blockValid && blockDirty)
                                state_q <= VICTIM;
                            else if (isWriteCmd(cmdCode)
                                && !isCachedZone(zoneIn))
                                state_q <= STORE;
                            else
                                state_q <= FETCH;
                        end else if (isHostZone(zoneIn)) begin
                            state_q <= HOST;
                        end else begin
                            state_q <= ANSWER;
                        end
                        // expansion zone left to outside logic
                    end
                end
                VICTIM:  if (cntDone) state_q <= FETCH;
                FETCH: begin
                    if (cntDone) begin
                        if (isCachedZone(zone_q))
                            state_q <= FILL;
                        else
                            state_q <= ANSWER;
                    end
                end
                FILL:    state_q <= ANSWER;
                STORE:   if (cntDone) state_q <= ANSWER;
                HOST:    if (!hostReady_n) state_q <= ANSWER;
                ANSWER:  state_q <= IDLE;
                default: state_q <= IDLE;
            endcase
        end
    end

    // ****************************************
    // memory side strobes
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dramVictimWr    <= 1'b0;
            dramRead        <= 1'b0;
            dramWrite       <= 1'b0;
            bcacheFill      <= 1'b0;
            bcacheMerge     <= 1'b0;
            bcacheMarkDirty <= 1'b0;
            cmdBusy         <= 1'b0;
        end else begin
            dramVictimWr <= (state_q == VICTIM);
            dramRead     <= (state_q == FETCH);
            // uncached writes go straight to dram
            dramWrite    <= (state_q == STORE);
            bcacheFill   <= (state_q == FILL) && !isWrite_q;
            bcacheMerge  <= (state_q == FILL) && isWrite_q;
            // line valid and dirty after merge
            bcacheMarkDirty <= (state_q == FILL) && isWrite_q;
            cmdBusy      <= busyNext;
        end
    end

    // ****************************************
    // answers to the processor
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            readAck   <= zone_decoder_pkg::ACK_NONE;
            cycleAck  <= 3'h0;
            cpuRdData <= 32'h00000000;
        end else begin
            readAck  <= zone_decoder_pkg::ACK_NONE;
            cycleAck <= 3'h0;
            if (state_q == ANSWER) begin
                if (isWrite_q)
                    cycleAck <= zone_decoder_pkg::CACK_OK;
                // no data cache load in this zone
                else if (zone_q == zone_decoder_pkg::ZONE_NODCACHE)
                    readAck <= zone_decoder_pkg::ACK_NODCACHE;
                else
                    readAck <= zone_decoder_pkg::ACK_FILL;
                if (zone_q == zone_decoder_pkg::ZONE_ROM)
                    cpuRdData <= {sysReg, romData};
                else if (addr_q[33])
                    cpuRdData <= hostData_q;
            end
            // barrier in expansion zone ends here
            if (state_q == IDLE && cmdValid && cpuAddr[33:32] == 2'h3
                && cmdCode == zone_decoder_pkg::CMD_BARRIER)
                cycleAck <= zone_decoder_pkg::CACK_OK;
        end
    end

    // ****************************************
    // system register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            sysReg <= zone_decoder_pkg::SYSREG_RST;
        else if (state_q == ANSWER && isWrite_q
                 && zone_q == zone_decoder_pkg::ZONE_ROM)
            sysReg <= wdata_q[zone_decoder_pkg::SYSREG_HI:
                              zone_decoder_pkg::SYSREG_LO];
    end

    // ****************************************
    // io address and byte lanes
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ioAddr                  <= 30'h00000000;
            peripheral_byte_lanes   <= zone_decoder_pkg::LANES_OFF;
            expansion_byte_lanes    <= 2'h0;
            expansion_transfer_size <= 2'h0;
            expansionSelect         <= 1'b0;
            romAddr                 <= '0;
        end else begin
            // upper from register, lower from 29:9
            ioAddr <= {sysReg[23:15], cpuAddr[29:9]};
            peripheral_byte_lanes <= cpuAddr[33] ?
                laneDecode(cpuAddr[8:5]) : zone_decoder_pkg::LANES_OFF;
            expansion_byte_lanes    <= cpuAddr[8:7];
            expansion_transfer_size <= cpuAddr[6:5];
            expansionSelect <= cmdValid && cpuAddr[33:32] == 2'h3;
            romAddr <= cpuAddr[ROM_AW+8:9];
        end
    end

    // ****************************************
    // dma address path
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            dmaCpuAddr <= 22'h000000;
        else if (dmaActive)
            dmaCpuAddr <= {dmaIoAddr,
                           octaword_select_upper | octaword_select_lower};
    end

    // ****************************************
    // peripheral host bus
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hostAddrStrobe_n <= 1'b1;
            hostMemIo        <= 1'b0;
            hostDataCtl      <= 1'b0;
            hostWriteRead    <= 1'b0;
        end else begin
            hostAddrStrobe_n <= !hostStart;
            if (hostStart) begin
                hostMemIo     <= (zoneIn == zone_decoder_pkg::ZONE_PMEM);
                hostDataCtl   <= (zoneIn != zone_decoder_pkg::ZONE_INTACK);
                hostWriteRead <= (zoneIn != zone_decoder_pkg::ZONE_INTACK)
                    && isWriteCmd(cmdCode);
            end
        end
    end

    // ****************************************
    // host read data
    // ****************************************
    // data taken on the ready edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            hostData_q <= 32'h00000000;
        else if (state_q == HOST && !hostReady_n)
            hostData_q <= hostRdData;
    end
endmodule // cpu_address_zone_decoder

// file: zone_decoder_checker.sv
// assertion checker for the cpu address zone decoder
`timescale 1ns/1ps
module zone_decoder_checker (
    // watched ports
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        cmdValid,
    input wire logic [2:0]  cmdCode,
    input wire logic [33:0] cpuAddr,
    input wire logic        cmdBusy,
    input wire logic [2:0]  readAck,
    input wire logic [2:0]  cycleAck,
    input wire logic [31:0] cpuRdData,
    input wire logic        dramVictimWr,
    input wire logic        bcacheFill,
    input wire logic [31:2] ioAddr,
    input wire logic [3:0]  peripheral_byte_lanes,
    input wire logic [1:0]  expansion_byte_lanes,
    input wire logic [1:0]  expansion_transfer_size,
    input wire logic        dmaActive,
    input wire logic [25:5] dmaIoAddr,
    input wire logic        octaword_select_upper,
    input wire logic        octaword_select_lower,
    input wire logic [25:4] dmaCpuAddr,
    input wire logic [23:0] sysReg,
    input wire logic        hostAddrStrobe_n,
    input wire logic        hostMemIo,
    input wire logic        hostDataCtl,
    input wire logic        hostWriteRead
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic hostZone;
    assign take = cmdValid && !cmdBusy;
    assign hostZone = cpuAddr[33:32] == 2'h2 && cpuAddr[31:30] != 2'h0;
    a_byte_lanes: assert property (
        $past(rst_n) && $past(cpuAddr[33]) && $past(cpuAddr[8:5]) == 4'h0
        |-> peripheral_byte_lanes == 4'he) else $error("byte lanes wrong");
    a_lanes_off: assert property (
        $past(rst_n) && (!$past(cpuAddr[33]) || $past(cpuAddr[8:5]) == 4'hd)
        |-> peripheral_byte_lanes == 4'hf) else $error("lanes not off");
    a_expansion_pair: assert property (
        $past(rst_n) |-> {expansion_byte_lanes, expansion_transfer_size}
        == $past(cpuAddr[8:5])) else $error("expansion pair wrong");
    a_io_map: assert property (
        $past(rst_n) && $stable(sysReg) |-> ioAddr
        == {sysReg[23:15], $past(cpuAddr[29:9])}) else $error("io map wrong");
    a_dma_pass: assert property (
        $past(rst_n) && $past(dmaActive) |-> dmaCpuAddr == {$past(dmaIoAddr),
        $past(octaword_select_upper) | $past(octaword_select_lower)})
        else $error("dma address wrong");
    a_host_strobe: assert property (
        take && hostZone && cmdCode != 3'h3
        |=> !hostAddrStrobe_n ##1 hostAddrStrobe_n)
        else $error("host strobe wrong");
    a_host_type: assert property (
        take && hostZone && cmdCode != 3'h3 |=> hostDataCtl
        == $past(cpuAddr[31]) && hostMemIo == ($past(cpuAddr[31])
        && !$past(cpuAddr[30])) && hostWriteRead == ($past(cmdCode) == 3'h2
        && $past(cpuAddr[31]))) else $error("host type wrong");
    a_barrier_ack: assert property (
        take && cpuAddr[33:32] == 2'h3 && cmdCode == 3'h3
        |=> cycleAck == 3'h1 && !cmdBusy) else $error("barrier ack wrong");
    a_rom_read: assert property (
        take && cpuAddr[33:30] == 4'h8 && cmdCode == 3'h1 |-> ##2
        readAck != 3'h0 && cpuRdData[31:8] == sysReg) else $error("rom read");
    a_no_victim: assert property (
        take && cpuAddr[33:31] == 3'h2 |=> (!dramVictimWr && !bcacheFill)[*8])
        else $error("uncached zone used backup cache");
endmodule // zone_decoder_checker

bind cpu_address_zone_decoder zone_decoder_checker chk_u (.ref_clk, .rst_n,
    .cmdValid, .cmdCode, .cpuAddr, .cmdBusy, .readAck, .cycleAck, .cpuRdData,
    .dramVictimWr, .bcacheFill, .ioAddr, .peripheral_byte_lanes,
    .expansion_byte_lanes, .expansion_transfer_size, .dmaActive, .dmaIoAddr,
    .octaword_select_upper, .octaword_select_lower, .dmaCpuAddr, .sysReg,
    .hostAddrStrobe_n, .hostMemIo, .hostDataCtl, .hostWriteRead);

// file: host_bus_model.sv
// peripheral host bus responder and debug rom for the bench
`timescale 1ns/1ps
module host_bus_model #(
    parameter int ROM_AW = 20
) (
    // clock and host bus
    input  wire logic              ref_clk,
    input  wire logic              hostAddrStrobe_n,
    output logic                   hostReady_n,
    output logic      [31:0]       hostRdData,
    input  wire logic [2:0]        waitCyc,
    // debug rom
    input  wire logic [ROM_AW-1:0] romAddr,
    output logic      [7:0]        romData
);
    logic [2:0] cnt = 3'h0;
    logic       busy = 1'b0;
    initial hostReady_n = 1'b1;
    initial hostRdData = 32'h0;
    assign romData = romAddr[7:0] ^ romAddr[15:8] ^ 8'h3c;
    always @(posedge ref_clk) begin
        hostReady_n <= !(busy && hostAddrStrobe_n && cnt == 3'h0);
        if (busy && hostAddrStrobe_n && cnt == 3'h0)
            hostRdData <= $urandom;
        else
            hostRdData <= ~hostRdData;
        if (!hostAddrStrobe_n) begin
            busy <= 1'b1;
            cnt <= waitCyc;
        end else if (busy && cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end else if (busy) begin
            busy <= 1'b0;
        end
    end
endmodule // host_bus_model

// file: tb.sv
// self-checking bench for the cpu address zone decoder
`timescale 1ns/1ps
module tb;
    // ****************
    // signals and units
    // ****************
    logic ref_clk, rst_n, cmdValid, blockValid, blockDirty, dmaActive;
    logic octaword_select_upper, octaword_select_lower, hostReady_n;
    logic cmdBusy, dramVictimWr, dramRead, dramWrite, bcacheFill;
    logic bcacheMerge, bcacheMarkDirty, expansionSelect, hostAddrStrobe_n;
    logic hostMemIo, hostDataCtl, hostWriteRead;
    logic [2:0] cmdCode, readAck, cycleAck, waitCyc, rAck, cAck, typ;
    logic [33:0] cpuAddr, a;
    logic [31:0] cpuWrData, cpuRdData, hostRdData, rData, hData, wd;
    logic [31:2] ioAddr;
    logic [3:0] peripheral_byte_lanes;
    logic [1:0] expansion_byte_lanes, expansion_transfer_size;
    logic [25:5] dmaIoAddr;
    logic [25:4] dmaCpuAddr;
    logic [19:0] romAddr;
    logic [7:0] romData;
    logic [23:0] sysReg, sv;
    logic sawV, sawF, sawM, sawD, sawW, sawX;
    int error_cnt, n_compared, nS;
    logic [3:0] hz [5] = '{4'h9, 4'ha, 4'ha, 4'hb, 4'hb};
    logic [2:0] ht [5] = '{3'h0, 3'h6, 3'h7, 3'h2, 3'h3};
    logic [3:0] mz [7] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h6, 4'h0, 4'h4};
    cpu_address_zone_decoder dut_u (.ref_clk, .rst_n, .cmdValid, .cmdCode,
        .cpuAddr, .cpuWrData, .blockValid, .blockDirty, .readAck, .cycleAck,
        .cpuRdData, .cmdBusy, .dramVictimWr, .dramRead, .dramWrite,
        .bcacheFill, .bcacheMerge, .bcacheMarkDirty, .ioAddr,
        .peripheral_byte_lanes, .expansion_byte_lanes,
        .expansion_transfer_size, .expansionSelect, .dmaActive, .dmaIoAddr,
        .octaword_select_upper, .octaword_select_lower, .dmaCpuAddr,
        .romAddr, .romData, .sysReg, .hostAddrStrobe_n, .hostMemIo,
        .hostDataCtl, .hostWriteRead, .hostReady_n, .hostRdData);
    host_bus_model far_u (.ref_clk, .hostAddrStrobe_n, .hostReady_n,
        .hostRdData, .waitCyc, .romAddr, .romData);
    // ****************
    // helpers
    // ****************
    function automatic logic [3:0] lanesFor(input logic [3:0] c);
        logic [3:0] t [16] = '{4'he, 4'hc, 4'h8, 4'hf, 4'hd, 4'h9, 4'h1,
            4'hf, 4'hb, 4'h3, 4'hf, 4'h0, 4'h7, 4'hf, 4'hf, 4'hf};
        return t[c];
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        n_compared++;
        if (seen !== want) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic issue(input logic [2:0] code, input logic [33:0] ad,
        input logic bv, input logic bd);
        @(posedge ref_clk);
        wd = $urandom;
        {cmdValid, cmdCode, cpuAddr, cpuWrData} <= {1'b1, code, ad, wd};
        {blockValid, blockDirty} <= {bv, bd};
        {sawV, sawF, sawM, sawD, sawW, sawX, rAck, cAck, nS} = '0;
        for (int i = 0; i < 80; i++) begin
            @(posedge ref_clk);
            cmdValid <= 1'b0;
            #1;
            sawV |= dramVictimWr && rAck == 3'h0;
            {sawF, sawM} |= {bcacheFill, bcacheMerge};
            {sawD, sawW, sawX} |= {bcacheMarkDirty, dramWrite, expansionSelect};
            if (!hostAddrStrobe_n) nS++;
            if (!hostAddrStrobe_n) typ = {hostMemIo, hostDataCtl, hostWriteRead};
            if (!hostReady_n) hData = hostRdData;
            if (readAck != 3'h0) {rAck, rData} = {readAck, cpuRdData};
            if (cycleAck != 3'h0) cAck = cycleAck;
            if ((rAck | cAck) != 3'h0 && !cmdBusy) return;
        end
        error_cnt++;
        tally_and_finish();
    endtask
    // ****************
    // stimulus
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_n, cmdValid, blockValid, blockDirty, dmaActive} = '0;
        {cmdCode, cpuAddr, cpuWrData, dmaIoAddr, waitCyc} = '0;
        {octaword_select_upper, octaword_select_lower} = '0;
        {error_cnt, n_compared} = '0;
        void'($urandom(32'h2b3b87d2));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 chk({sysReg, peripheral_byte_lanes}, 28'h000000f);
        issue(3'h2, {4'h8, 30'($urandom)}, 1'b0, 1'b0);
        sv = wd[31:8];
        chk(sysReg, sv);
        a = {4'h8, 30'($urandom)};
        issue(3'h1, a, 1'b0, 1'b0);
        chk(rData, {sv, a[16:9] ^ a[24:17] ^ 8'h3c});
        for (int i = 0; i < 48; i++) begin
            a = {2'($urandom), $urandom};
            if (i < 16) a[33] = 1'b1;
            if (i < 16) a[8:5] = 4'(i);
            @(posedge ref_clk) cpuAddr <= a;
            @(posedge ref_clk) #1;
            chk(peripheral_byte_lanes,
                a[33] ? lanesFor(a[8:5]) : 4'hf);
            chk({expansion_byte_lanes, expansion_transfer_size},
                a[8:5]);
            chk(ioAddr, {sv[23:15], a[29:9]});
        end
        for (int k = 0; k < 5; k++) begin
            waitCyc <= 3'($urandom_range(3, 0));
            a = {hz[k], 30'($urandom)};
            // software keeps to legal lane codes
            if (lanesFor(a[8:5]) == 4'hf) a[8:5] = 4'hb;
            issue(k == 2 || k == 4 ? 3'h2 : 3'h1, a, 1'b0, 1'b0);
            chk({nS[3:0], typ}, {4'h1, ht[k]});
            chk(ht[k][0] ? cAck : rData, ht[k][0] ? 3'h1 : hData);
        end
        for (int k = 0; k < 7; k++) begin
            issue(k > 4 ? 3'h2 : 3'h1, {mz[k], 30'($urandom)},
                k != 2, k != 0);
            chk(sawV, k == 1 || k == 5);
            if (k > 4) chk({sawM & sawD, cAck}, {k == 5, 3'h1});
            if (k < 5) chk(sawF, k < 3);
            if (k < 3) chk(rAck, zone_decoder_pkg::ACK_FILL);
            if (k == 4) chk(rAck, zone_decoder_pkg::ACK_NODCACHE);
            if (k == 6) chk(sawW, 1'b1);
        end
        // only barriers reach the expansion zone
        issue(3'h3, {2'h3, $urandom}, 1'b0, 1'b0);
        chk({cAck, rAck, sawX}, {3'h1, 3'h0, 1'b1});
        for (int i = 0; i < 8; i++) begin
            a = $urandom;
            @(posedge ref_clk) {dmaActive, dmaIoAddr} <= {1'b1, a[25:5]};
            {octaword_select_upper, octaword_select_lower} <= a[1:0];
            @(posedge ref_clk) #1;
            chk(dmaCpuAddr, {a[25:5], |a[1:0]});
        end
        tally_and_finish();
    end
endmodule // tb
